// File: tfs_defs.vh
`ifndef TFS_DEFS_VH
`define TFS_DEFS_VH

// ------------------------------------------------------------
// register offsets (byte addresses, wishbone)
// ------------------------------------------------------------
`define TFS_ADDR_W 8
`define TFS_OFF_CTRL 8'h00
`define TFS_OFF_TAG0 8'h04
`define TFS_OFF_TAG1 8'h08
`define TFS_OFF_ENT0 8'h0C
`define TFS_OFF_ENT1 8'h10
`define TFS_OFF_RET1 8'h14
`define TFS_OFF_ITAG 8'h18
`define TFS_OFF_IENT 8'h1C
`define TFS_OFF_STAT 8'h20
`define TFS_OFF_FSTAT 8'h24
`define TFS_OFF_FADDR 8'h28
`define TFS_OFF_FAULT 8'h2C
// ------------------------------------------------------------
// fields
// ------------------------------------------------------------
`define TFS_CTRL_BAR_BIT 0
`define TFS_FAULT_NEST_BIT 31
`define TFS_GH_LSB 5
`define TFS_GH_MSB 6
`define TFS_SB_LOW 4'hF
`define TFS_SB_HIGH 4'hF
`define TFS_BAR_CYC 4'h4
`endif

// File: tfs_cam.v
`timescale 1ns/1ps
`include "tfs_defs.vh"
module tfs_cam #(
  parameter DEPTH = 8,
  parameter IDX_W = 3,
  parameter TAG_W = 32,
  parameter ENT_W = 32
) (
  clk,
  reset,
  wrEn,
  wrTag,
  wrEnt,
  lookupEn,
  lookupTag,
  hit,
  hitEnt
);
  input wire clk;
  input wire reset;
  input wire wrEn;
  input wire [TAG_W-1:0] wrTag;
  input wire [ENT_W-1:0] wrEnt;
  input wire lookupEn;
  input wire [TAG_W-1:0] lookupTag;
  output reg hit;
  output reg [ENT_W-1:0] hitEnt;

  reg [TAG_W-1:0] tagMem [0:DEPTH-1];
  reg [ENT_W-1:0] entMem [0:DEPTH-1];
  reg [DEPTH-1:0] valid_r;
  reg [IDX_W-1:0] victim_r;
  wire [DEPTH-1:0] match;
  wire [DEPTH-1:0] lmatch;
  reg anyHit;
  reg [ENT_W-1:0] selEnt;
  integer k;

  genvar g;
  generate
    for (g = 0; g < DEPTH; g = g + 1) begin : cmp
      assign match[g] = valid_r[g] && (tagMem[g] == wrTag);
      assign lmatch[g] = valid_r[g] && (tagMem[g] == lookupTag);
    end
  endgenerate

  always @* begin
    anyHit = 1'b0;
    selEnt = {ENT_W{1'b0}};
    for (k = 0; k < DEPTH; k = k + 1) begin
      if (lmatch[k]) begin
        anyHit = 1'b1;
        selEnt = entMem[k];
      end
    end
  end

  // single write port keeps tag and entry together
  always @(posedge clk) begin
    if (wrEn && (match == {DEPTH{1'b0}})) begin
      tagMem[victim_r] <= wrTag;
      entMem[victim_r] <= wrEnt;
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      valid_r <= {DEPTH{1'b0}};
      victim_r <= {IDX_W{1'b0}};
      hit <= 1'b0;
      hitEnt <= {ENT_W{1'b0}};
    end else begin
      if (wrEn && (match == {DEPTH{1'b0}})) begin
        valid_r[victim_r] <= 1'b1;
        victim_r <= victim_r + 1'b1;
      end
      hit <= lookupEn && anyHit;
      if (lookupEn) begin
        hitEnt <= selEnt;
      end
    end
  end
endmodule

// File: tfs_barrier.v
`timescale 1ns/1ps
`include "tfs_defs.vh"
module tfs_barrier (
  clk,
  reset,
  start,
  storesDrained,
  busy
);
  input wire clk;
  input wire reset;
  input wire start;
  input wire storesDrained;
  output reg busy;

  reg [3:0] cnt_r;

  // reads held until min time passed and stores drained
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      busy <= 1'b0;
      cnt_r <= 4'h0;
    end else if (start) begin
      busy <= 1'b1;
      cnt_r <= `TFS_BAR_CYC;
    end else if (busy) begin
      if (cnt_r != 4'h0) begin
        cnt_r <= cnt_r - 4'h1;
      end else if (storesDrained) begin
        busy <= 1'b0;
      end
    end
  end
endmodule

// File: tfs_tlb_fill.v
// Design decisions made here: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`include "tfs_defs.vh"
module tfs_tlb_fill #(
  parameter DEPTH = 8,
  parameter IDX_W = 3
) (
  clk,
  reset,
  wb_cyc_i,
  wb_stb_i,
  wb_we_i,
  wb_adr_i,
  wb_sel_i,
  wb_dat_i,
  wb_dat_o,
  wb_ack_o,
  icacheMiss,
  fetchAddr,
  itlbHit,
  itlbEntry,
  dataLookupEn,
  dataLookupTag,
  dtlbHit,
  dtlbEntry,
  loadStoreHold,
  barrierActive,
  storesDrained
);
  input wire clk;
  input wire reset;
  input wire wb_cyc_i;
  input wire wb_stb_i;
  input wire wb_we_i;
  input wire [`TFS_ADDR_W-1:0] wb_adr_i;
  input wire [3:0] wb_sel_i;
  input wire [31:0] wb_dat_i;
  output reg [31:0] wb_dat_o;
  output reg wb_ack_o;
  input wire icacheMiss;
  input wire [31:0] fetchAddr;
  output wire itlbHit;
  output wire [31:0] itlbEntry;
  input wire dataLookupEn;
  input wire [31:0] dataLookupTag;
  output wire dtlbHit;
  output wire [31:0] dtlbEntry;
  output reg loadStoreHold;
  output wire barrierActive;
  input wire storesDrained;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  reg barrierOnRefillEnable_r;
  reg [31:0] tag0_r;
  reg [31:0] tag1_r;
  reg [31:0] ent0_r;
  reg [31:0] ent1_r;
  reg [31:0] itag_r;
  reg [3:0] sbLow_r;
  reg [3:0] sbHigh_r;
  reg pendingEnt1_r;
  reg [31:0] faultStat_r;
  reg [31:0] faultAddr_r;
  reg dCommit;
  reg iCommit;
  reg barStart;
  reg [31:0] rdData;
  reg ackDrop_r;

  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && !ackDrop_r;
  wire wr = req && wb_we_i;
  // ent1 retire arrives as a separate write
  wire retire = wr && (wb_adr_i == `TFS_OFF_RET1);

  function [31:0] mergeBytes;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] sel;
    begin
      mergeBytes = {sel[3] ? nw[31:24] : old[31:24],
                    sel[2] ? nw[23:16] : old[23:16],
                    sel[1] ? nw[15:8] : old[15:8],
                    sel[0] ? nw[7:0] : old[7:0]};
    end
  endfunction

  function isAddr;
    input [`TFS_ADDR_W-1:0] a;
    input [`TFS_ADDR_W-1:0] b;
    begin
      isAddr = (a == b);
    end
  endfunction

  // a new set opens with tag0; a tag0 write before the prior retire is acked and dropped
  wire setBlocked = isAddr(wb_adr_i, `TFS_OFF_TAG0) && (sbHigh_r != 4'h0);

  // ------------------------------------------------------------
  // write side
  // ------------------------------------------------------------
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      barrierOnRefillEnable_r <= 1'b0;
      tag0_r <= 32'h00000000;
      tag1_r <= 32'h00000000;
      ent0_r <= 32'h00000000;
      ent1_r <= 32'h00000000;
      itag_r <= 32'h00000000;
      sbLow_r <= 4'h0;
      sbHigh_r <= 4'h0;
      pendingEnt1_r <= 1'b0;
      faultStat_r <= 32'h00000000;
      faultAddr_r <= 32'h00000000;
      dCommit <= 1'b0;
      iCommit <= 1'b0;
      barStart <= 1'b0;
      wb_ack_o <= 1'b0;
      ackDrop_r <= 1'b0;
      wb_dat_o <= 32'h00000000;
      loadStoreHold <= 1'b0;
    end else begin
      dCommit <= 1'b0;
      iCommit <= 1'b0;
      barStart <= 1'b0;
      wb_ack_o <= req;
      ackDrop_r <= wb_ack_o;
      if (req) begin
        wb_dat_o <= rdData;
      end
      // rest of the open set still lands; only a fresh tag0 is dropped
      if (wr && !setBlocked) begin
        if (isAddr(wb_adr_i, `TFS_OFF_CTRL)) begin
          barrierOnRefillEnable_r <= wb_dat_i[`TFS_CTRL_BAR_BIT];
        end else if (isAddr(wb_adr_i, `TFS_OFF_TAG0)) begin
          tag0_r <= mergeBytes(tag0_r, wb_dat_i, wb_sel_i);
          sbHigh_r <= `TFS_SB_HIGH;
          sbLow_r <= `TFS_SB_LOW;
        end else if (isAddr(wb_adr_i, `TFS_OFF_TAG1)) begin
          tag1_r <= mergeBytes(tag1_r, wb_dat_i, wb_sel_i);
        end else if (isAddr(wb_adr_i, `TFS_OFF_ENT0)) begin
          ent0_r <= mergeBytes(ent0_r, wb_dat_i, wb_sel_i);
          barStart <= barrierOnRefillEnable_r;
          sbLow_r <= `TFS_SB_LOW;
        end else if (isAddr(wb_adr_i, `TFS_OFF_ENT1)) begin
          ent1_r <= mergeBytes(ent1_r, wb_dat_i, wb_sel_i);
          pendingEnt1_r <= 1'b1;
        end else if (isAddr(wb_adr_i, `TFS_OFF_RET1)) begin
          if (pendingEnt1_r) begin
            dCommit <= 1'b1;
            pendingEnt1_r <= 1'b0;
            sbHigh_r <= 4'h0;
            sbLow_r <= 4'h0;
          end
        end else if (isAddr(wb_adr_i, `TFS_OFF_ITAG)) begin
          itag_r <= mergeBytes(itag_r, wb_dat_i, wb_sel_i);
        end else if (isAddr(wb_adr_i, `TFS_OFF_IENT)) begin
          iCommit <= 1'b1;
        end else if (isAddr(wb_adr_i, `TFS_OFF_FAULT)) begin
          // nested table-fetch miss keeps first fault info
          if (!wb_dat_i[`TFS_FAULT_NEST_BIT]) begin
            faultStat_r <= {1'b0, wb_dat_i[`TFS_FAULT_NEST_BIT-1:0]};
            faultAddr_r <= fetchAddr;
          end
        end
      end
      // scoreboard set until retire holds loads; barrier busy holds them too
      loadStoreHold <= (sbLow_r != 4'h0) || barrierActive;
    end
  end

  // ------------------------------------------------------------
  // read side
  // ------------------------------------------------------------
  always @* begin
    rdData = 32'h00000000;
    if (isAddr(wb_adr_i, `TFS_OFF_CTRL)) begin
      rdData = {31'h00000000, barrierOnRefillEnable_r};
    end else if (isAddr(wb_adr_i, `TFS_OFF_TAG0)) begin
      rdData = tag0_r;
    end else if (isAddr(wb_adr_i, `TFS_OFF_TAG1)) begin
      rdData = tag1_r;
    end else if (isAddr(wb_adr_i, `TFS_OFF_ENT0)) begin
      rdData = ent0_r;
    end else if (isAddr(wb_adr_i, `TFS_OFF_ENT1)) begin
      rdData = ent1_r;
    end else if (isAddr(wb_adr_i, `TFS_OFF_STAT)) begin
      rdData = {22'h000000, barrierActive, pendingEnt1_r,
                sbHigh_r, sbLow_r};
    end else if (isAddr(wb_adr_i, `TFS_OFF_FSTAT)) begin
      rdData = faultStat_r;
    end else if (isAddr(wb_adr_i, `TFS_OFF_FADDR)) begin
      rdData = faultAddr_r;
    end
  end

  // ------------------------------------------------------------
  // barrier and arrays
  // ------------------------------------------------------------
  tfs_barrier u_bar (
    .clk(clk),
    .reset(reset),
    .start(barStart),
    .storesDrained(storesDrained),
    .busy(barrierActive)
  );

  // commit uses tag0 for data side
  tfs_cam #(.DEPTH(DEPTH), .IDX_W(IDX_W)) u_dtlb (
    .clk(clk),
    .reset(reset),
    .wrEn(dCommit),
    .wrTag(tag0_r),
    .wrEnt(ent0_r),
    .lookupEn(dataLookupEn),
    .lookupTag(dataLookupTag),
    .hit(dtlbHit),
    .hitEnt(dtlbEntry)
  );

  tfs_cam #(.DEPTH(DEPTH), .IDX_W(IDX_W)) u_itlb (
    .clk(clk),
    .reset(reset),
    .wrEn(iCommit),
    .wrTag(itag_r),
    .wrEnt(wb_dat_i),
    .lookupEn(icacheMiss),
    .lookupTag(fetchAddr),
    .hit(itlbHit),
    .hitEnt(itlbEntry)
  );
endmodule

// File: tfs_tlb_fill_monitor.sv
`timescale 1ns/1ps
`include "tfs_defs.vh"
module tfs_tlb_fill_monitor #(parameter DEPTH = 8, parameter IDX_W = 3) (
  input clk,
  input reset,
  input wb_cyc_i,
  input wb_stb_i,
  input wb_we_i,
  input [7:0] wb_adr_i,
  input [31:0] wb_dat_i,
  input wb_ack_o,
  input icacheMiss,
  input itlbHit,
  input dataLookupEn,
  input dtlbHit,
  input loadStoreHold,
  input barrierActive,
  input storesDrained
);
  // ----
  // shadow of the barrier enable
  // ----
  reg barEn;
  wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  always @(posedge clk or posedge reset)
    if (reset)
      barEn <= 1'b0;
    else if (wb_ack_o && wb_we_i && wb_adr_i == `TFS_OFF_CTRL)
      barEn <= wb_dat_i[0];
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_ack_next: assert property (take |=> wb_ack_o)
    else $error("no ack after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_bar_start: assert property (take && wb_we_i && barEn &&
    wb_adr_i == `TFS_OFF_ENT0 |-> ##[1:3] barrierActive)
    else $error("no barrier on first entry write");
  a_bar_needs_en: assert property ($rose(barrierActive) |-> barEn)
    else $error("barrier without enable");
  a_bar_min: assert property ($rose(barrierActive) |-> barrierActive[*4])
    else $error("barrier shorter than four cycles");
  a_bar_drain: assert property (barrierActive && !storesDrained
    |=> barrierActive) else $error("barrier left before drain");
  a_hold_bar: assert property (barrierActive && !storesDrained
    |=> loadStoreHold) else $error("loads not held in barrier");
  a_itlb_miss: assert property (itlbHit |-> $past(icacheMiss))
    else $error("itlb hit without cache miss");
  a_dtlb_look: assert property (dtlbHit |-> $past(dataLookupEn))
    else $error("dtlb hit without lookup");
endmodule
bind tfs_tlb_fill tfs_tlb_fill_monitor #(.DEPTH(DEPTH), .IDX_W(IDX_W))
  u_mon (.clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .icacheMiss(icacheMiss),
  .itlbHit(itlbHit), .dataLookupEn(dataLookupEn), .dtlbHit(dtlbHit),
  .loadStoreHold(loadStoreHold), .barrierActive(barrierActive),
  .storesDrained(storesDrained));

// File: tfs_fw_model.sv
`timescale 1ns/1ps
`include "tfs_defs.vh"
module tfs_fw_model (
  input clk,
  output reg cyc,
  output reg stb,
  output reg we,
  output reg [7:0] adr,
  output reg [3:0] sel,
  output reg [31:0] datW,
  input [31:0] datR,
  input ack
);
  // ----
  // handler register writes
  // ----
  initial {cyc, stb, we, adr, sel, datW} = 47'h0;
  // released lines inverted so a stale value never matches
  task xfer(input w, input [7:0] a, input [31:0] d, output [31:0] q);
    begin
      @(posedge clk);
      {cyc, stb, we, adr, sel, datW} <= {2'b11, w, a, 4'hF, d};
      @(posedge clk);
      while (!ack) @(posedge clk);
      q = datR;
      {cyc, stb, adr, datW} <= {2'b00, ~a, ~d};
    end
  endtask
  // whole writer set, never cut by a branch; repeat is harmless
  task stage(input [31:0] t, input [31:0] e);
    reg [31:0] q;
    begin
      xfer(1'b1, `TFS_OFF_TAG0, t, q);
      xfer(1'b1, `TFS_OFF_TAG1, t, q);
      xfer(1'b1, `TFS_OFF_ENT0, e, q);
      xfer(1'b1, `TFS_OFF_ENT1, e, q);
    end
  endtask
  // no entry barrier bit used, so enable alone picks the barrier
  task setBarrier(input en);
    reg [31:0] q;
    xfer(1'b1, `TFS_OFF_CTRL, {31'h0, en}, q);
  endtask
  // caller keeps fetch off until load returns, as a stalled return
  task loadInstr(input [31:0] t, input [31:0] e);
    reg [31:0] q;
    begin
      xfer(1'b1, `TFS_OFF_ITAG, t, q);
      xfer(1'b1, `TFS_OFF_IENT, e, q);
    end
  endtask
endmodule

// File: tb_tfs_tlb_fill.sv
`timescale 1ns/1ps
`include "tfs_defs.vh"
module tb_tfs_tlb_fill;
  reg clk = 0, reset = 1, icacheMiss = 0, dataLookupEn = 0;
  reg storesDrained = 1;
  reg [31:0] fetchAddr = 0, dataLookupTag = 0, seed = 32'h854E, t, e, q;
  wire cyc, stb, we, ack, itlbHit, dtlbHit, loadStoreHold, barrierActive;
  wire [7:0] adr;
  wire [3:0] sel;
  wire [31:0] datW, datR, itlbEntry, dtlbEntry;
  integer errTotal = 0, compares = 0, cycN = 0, i;
  tfs_tlb_fill #(.DEPTH(8), .IDX_W(3)) i_tfs_tlb_fill (.clk(clk),
    .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW), .wb_dat_o(datR),
    .wb_ack_o(ack), .icacheMiss(icacheMiss), .fetchAddr(fetchAddr),
    .itlbHit(itlbHit), .itlbEntry(itlbEntry), .dataLookupEn(dataLookupEn),
    .dataLookupTag(dataLookupTag), .dtlbHit(dtlbHit), .dtlbEntry(dtlbEntry),
    .loadStoreHold(loadStoreHold), .barrierActive(barrierActive),
    .storesDrained(storesDrained));
  tfs_fw_model i_tfs_fw_model (.clk(clk), .cyc(cyc), .stb(stb), .we(we),
    .adr(adr), .sel(sel), .datW(datW), .datR(datR), .ack(ack));
  // ----
  // helpers
  // ----
  initial forever #2.5 clk = ~clk;
  function [31:0] rnd;
    begin
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      rnd = seed;
    end
  endfunction
  function [31:0] entOf(input [31:0] r, input [1:0] gh);
    entOf = {r[31:7], gh, r[4:0]};
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        errTotal = errTotal + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task look(input [31:0] tg);
    begin
      @(posedge clk);
      dataLookupEn <= 1'b1;
      dataLookupTag <= tg;
      @(posedge clk);
      dataLookupEn <= 1'b0;
      #1;
    end
  endtask
  task giveVerdict;
    begin
      $display("compares=%0d mismatches=%0d", compares, errTotal);
      if (errTotal == 0 && compares > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  // ceiling well above the few hundred cycles the run needs
  always @(posedge clk) begin
    cycN <= cycN + 1;
    if (cycN == 4000) begin
      errTotal = errTotal + 1;
      giveVerdict;
    end
  end
  // ----
  // scenarios
  // ----
  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    for (i = 0; i < 4; i = i + 1) begin
      t = rnd();
      e = entOf(rnd(), i[1:0]);
      i_tfs_fw_model.stage(t, e);
      look(t);
      chk(dtlbHit, 0);
      chk(loadStoreHold, 1);
      i_tfs_fw_model.xfer(1'b0, `TFS_OFF_STAT, 0, q);
      chk(q[7:4], `TFS_SB_HIGH);
      i_tfs_fw_model.xfer(1'b1, `TFS_OFF_TAG0, ~t, q);
      i_tfs_fw_model.xfer(1'b1, `TFS_OFF_RET1, 0, q);
      i_tfs_fw_model.xfer(1'b0, `TFS_OFF_STAT, 0, q);
      chk(q, 0);
      chk(loadStoreHold, 0);
      look(t);
      chk(dtlbHit, 1);
      chk(dtlbEntry, e);
    end
    i_tfs_fw_model.stage(t, ~e);
    i_tfs_fw_model.xfer(1'b1, `TFS_OFF_RET1, 0, q);
    look(t);
    chk(dtlbEntry, e);
    $display("data fill done");
    i_tfs_fw_model.setBarrier(1'b1);
    storesDrained <= 1'b0;
    i_tfs_fw_model.stage(rnd(), entOf(rnd(), 2'h0));
    #1;
    chk(barrierActive, 1);
    chk(loadStoreHold, 1);
    @(posedge clk);
    storesDrained <= 1'b1;
    for (i = 0; i < 20 && barrierActive; i = i + 1) @(posedge clk);
    #1;
    chk(barrierActive, 0);
    i_tfs_fw_model.xfer(1'b1, `TFS_OFF_RET1, 0, q);
    i_tfs_fw_model.setBarrier(1'b0);
    $display("barrier done");
    t = rnd();
    e = rnd();
    i_tfs_fw_model.loadInstr(t, e);
    @(posedge clk);
    icacheMiss <= 1'b1;
    fetchAddr <= t;
    @(posedge clk);
    icacheMiss <= 1'b0;
    #1;
    chk(itlbHit, 1);
    chk(itlbEntry, e);
    @(posedge clk);
    #1;
    chk(itlbHit, 0);
    $display("instr fill done");
    e = rnd() & 32'h7FFFFFFF;
    i_tfs_fw_model.xfer(1'b1, `TFS_OFF_FAULT, e, q);
    fetchAddr <= ~t;
    i_tfs_fw_model.xfer(1'b1, `TFS_OFF_FAULT, ~e, q);
    i_tfs_fw_model.xfer(1'b0, `TFS_OFF_FSTAT, 0, q);
    chk(q, e);
    i_tfs_fw_model.xfer(1'b0, `TFS_OFF_FADDR, 0, q);
    chk(q, t);
    i_tfs_fw_model.xfer(1'b0, 8'hFC, 0, q);
    chk(q, 0);
    $display("fault hold done");
    giveVerdict;
  end
endmodule
